/* File: design/sacc_ctrl.sv */
// Functional notes
// (RL1) one analog source muxed to converter
// (RL2) idle channel switches power, partner pin grounds; code drives the panel only for the channel being converted
// (RL3) two control registers set converter behaviour
// (RL4) result stored in its channel's register
// (RL5) results are unsigned straight binary
// (RL6) resolution selectable 10 or 12 bits
// (RL7) 10-bit mode runs fewer steps
// (RL8) converter clock divided from oscillator
// (RL9) divider 00 runs undivided, 10-bit only
// (RL10) host pairs 12-bit with divider 01/10
// (RL11) fixed sample ticks plus settle delay
// (RL12) single temperature mode converts diode one
// (RL13) differential mode adds diode two conversion
// (RL14) results readable any time, no handshake
// (RL15) panel settle delay before conversion
// (RL16) 01 halves, 10 quarters, 11 reserved
// (RL17) 10-bit result in low bits, zero above
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog front end
  input  wire logic        comp_i,
  output logic [11:0]      dac_code_o,
  output logic             sample_o,
  output logic [2:0]       mux_sel_o,
  output logic [3:0]       panel_drv_o,
  output logic             temperature_diode_single_o,
  output logic             temperature_diode_ratio_o
);
  import sacc_pkg::*;

  sacc_res_if res ();

  // register decode, shared by read and write paths
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == CFG0_OFS) || (a == CFG1_OFS) || (a == STAT_OFS) ||
              ((a >= RES_OFS) && (a < RES_OFS + {3'h0, RES_NUM, 2'h0}));
  endfunction : reg_hit

  function automatic logic [2:0] res_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - RES_OFS;
    res_idx = d[4:2];
  endfunction : res_idx

  // first channel of each mode
  function automatic sacc_ch_t seq_first(input logic [3:0] m);
    case (m)
      MODE_Y:     seq_first = CH_Y;
      MODE_Z:     seq_first = CH_Z1;
      MODE_AUX:   seq_first = CH_AUX;
      MODE_TSGL,
      MODE_TDIFF: seq_first = CH_T1;
      default:    seq_first = CH_X;
    endcase
  endfunction : seq_first

  // true when the channel ends the mode's sequence
  function automatic logic seq_last(input logic [3:0] m, input sacc_ch_t c);
    case (m)
      MODE_XY:    seq_last = (c == CH_Y);
      MODE_XYZ,
      MODE_Z:     seq_last = (c == CH_Z2);
      MODE_TDIFF: seq_last = (c == CH_T2);
      default:    seq_last = 1'b1;
    endcase
  endfunction : seq_last

  // panel switches per channel: {x+ pwr, x- gnd, y+ pwr, y- gnd}
  function automatic logic [3:0] drv_of(input sacc_ch_t c);
    case (c)
      CH_X:         drv_of = 4'b1100;
      CH_Y:         drv_of = 4'b0011;
      CH_Z1, CH_Z2: drv_of = 4'b0110;
      default:      drv_of = 4'b0000;
    endcase
  endfunction : drv_of

  // ---------------- registers and state ----------------
  logic [7:0]  cfg0_q;
  logic [8:0]  cfg1_q;
  logic        done_q, err_q;
  logic        aw_have_q, w_have_q, rd_pend_q;
  logic [7:0]  awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  sacc_state_t st_q;
  sacc_ch_t    ch_q;
  logic [3:0]  mode_q;
  logic        res12_q;
  logic [1:0]  div_q;
  logic [5:0]  osc_cnt_q;
  logic [1:0]  pre_q;
  logic [7:0]  stab_q;
  logic [1:0]  smp_q;
  logic [11:0] sar_q;
  logic [3:0]  bit_q;

  // ---------------- axi write path ----------------
  wire         do_wr    = aw_have_q && w_have_q && !s_axi_bvalid;
  wire         wr_hit   = reg_hit(awaddr_q);
  wire         wr_cfg0  = do_wr && (awaddr_q == CFG0_OFS) && wstrb_q[0];
  wire         wr_cfg1  = do_wr && (awaddr_q == CFG1_OFS);
  wire         wr_stat  = do_wr && (awaddr_q == STAT_OFS) && wstrb_q[0];
  wire [3:0]   new_mode = wdata_q[C0_MODE_LSB +: 4];
  wire [1:0]   new_div  = wdata_q[C0_DIV_LSB +: 2];
  wire         new_r12  = wdata_q[C0_RES12];
  wire         busy     = (st_q != S_IDLE);
  wire         start_rq = wr_cfg0 && wdata_q[C0_START];
  // reserved divider or 12-bit on the undivided clock is flagged
  wire         cfg_bad  = (new_div == DIV_RSV) || (new_r12 && (new_div == DIV_BY1)); // [RL9] [RL16]
  wire         start_ok = start_rq && !busy && (new_div != DIV_RSV);             // [RL16]
  wire         seq_end;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;

  // address and data are taken in either order, then paired
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (do_wr) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; start bit is a pulse and is not stored
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg0_q <= CFG0_RST;
      cfg1_q <= CFG1_RST;
    end else begin
      if (wr_cfg0) begin
        cfg0_q <= {1'b0, wdata_q[6:0]};                                            // [RL3]
      end
      if (wr_cfg1) begin
        if (wstrb_q[0]) cfg1_q[7:0] <= wdata_q[7:0];                              // [RL3]
        if (wstrb_q[1]) cfg1_q[8]   <= wdata_q[C1_SCAN];
      end
    end
  end

  // sticky flags: hardware set wins over a write-one clear
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      done_q <= seq_end || (done_q && !(wr_stat && wdata_q[ST_DONE]));
      err_q  <= (start_rq && cfg_bad) || (err_q && !(wr_stat && wdata_q[ST_ERR]));
    end
  end

  // ---------------- axi read path ----------------
  wire [31:0] stat_w = {29'h0, err_q, done_q, busy};
  wire [31:0] rd_mux =
      (araddr_q == CFG0_OFS) ? {24'h0, cfg0_q} :
      (araddr_q == CFG1_OFS) ? {23'h0, cfg1_q} :
      (araddr_q == STAT_OFS) ? stat_w :
      reg_hit(araddr_q)      ? {20'h0, res.rd_data} : 32'h0000_0000;         // [RL14] [RL17]

  assign s_axi_arready = !rd_pend_q && !s_axi_rvalid;
  assign res.rd_idx    = res_idx(s_axi_araddr);

  // memory reads on the edge that takes the address, answer follows one cycle later
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_pend_q    <= 1'b0;
      araddr_q     <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      rd_pend_q <= s_axi_arvalid && s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        araddr_q <= s_axi_araddr;
      end
      if (rd_pend_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= reg_hit(araddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- clocks ----------------
  wire osc_tick  = (osc_cnt_q == 6'h00);
  // undivided, half or quarter of the oscillator
  wire conv_tick = osc_tick && ((div_q == DIV_BY1) ||
                                ((div_q == DIV_BY2) && pre_q[0]) ||
                                ((div_q == DIV_BY4) && (pre_q == 2'h3))); // [RL8] [RL9] [RL16]

  // oscillator stand-in and conversion prescaler
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_cnt_q <= OSC_DIV_M1;
      pre_q     <= 2'h0;
    end else begin
      osc_cnt_q <= osc_tick ? OSC_DIV_M1 : osc_cnt_q - 6'h01;
      if (osc_tick) pre_q <= pre_q + 2'h1;
    end
  end

  // ---------------- conversion sequencer ----------------
  wire        is_panel = (drv_of(ch_q) != 4'b0000);
  wire [3:0]  lsb_pos  = res12_q ? 4'h0 : 4'h2;                                 // [RL7]
  wire        last     = seq_last(mode_q, ch_q);
  assign seq_end = (st_q == S_STORE) && last && !cfg1_q[C1_SCAN];

  // result store: 10-bit codes shifted into the low bits
  assign res.wr_en   = (st_q == S_STORE);                                       // [RL4]
  assign res.wr_idx  = ch_q;                                                    // [RL4]
  assign res.wr_data = res12_q ? sar_q : {2'b00, sar_q[11:2]};                  // [RL5] [RL17]

  // a new conversion is refused while one is running
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q    <= S_IDLE;
      ch_q    <= CH_X;
      mode_q  <= MODE_X;
      res12_q <= 1'b0;
      div_q   <= DIV_BY1;
      stab_q  <= 8'h00;
      smp_q   <= 2'h0;
      sar_q   <= 12'h000;
      bit_q   <= 4'h0;
    end else begin
      case (st_q)
        S_IDLE: begin
          if (start_ok) begin
            mode_q  <= new_mode;
            div_q   <= new_div;
            res12_q <= new_r12 && (new_div != DIV_BY1);                         // [RL6] [RL9]
            ch_q    <= seq_first(new_mode);                                     // [RL12] [RL13]
            stab_q  <= cfg1_q[C1_STAB_LSB +: 8];
            st_q    <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          // only panel channels wait for the plates to settle
          if (!is_panel || stab_q == 8'h00) begin                               // [RL15]
            smp_q <= 2'h0;
            st_q  <= S_SAMPLE;
          end else if (osc_tick) begin
            stab_q <= stab_q - 8'h01;                                           // [RL11]
          end
        end
        S_SAMPLE: begin
          if (osc_tick) begin
            if (smp_q == SAMPLE_TICKS - 2'h1) begin                             // [RL11]
              sar_q <= 12'h800;
              bit_q <= 4'hb;
              st_q  <= S_CONV;
            end else begin
              smp_q <= smp_q + 2'h1;
            end
          end
        end
        S_CONV: begin
          // comparator high keeps the trial bit
          if (conv_tick) begin
            if (!comp_i) sar_q[bit_q] <= 1'b0;                                  // [RL5]
            if (bit_q == lsb_pos) begin                                         // [RL7]
              st_q <= S_STORE;
            end else begin
              sar_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
            end
          end
        end
        S_STORE: begin
          stab_q <= cfg1_q[C1_STAB_LSB +: 8];
          if (!last) begin
            ch_q <= sacc_ch_t'(ch_q + 3'h1);                                    // [RL13]
            st_q <= S_SETTLE;
          end else if (cfg1_q[C1_SCAN]) begin
            ch_q <= seq_first(mode_q);                                          // [RL3]
            st_q <= S_SETTLE;
          end else begin
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // front-end pins registered; one system cycle of lag is negligible
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mux_sel_o                  <= 3'h0;
      panel_drv_o                <= 4'h0;
      temperature_diode_single_o <= 1'b0;
      temperature_diode_ratio_o  <= 1'b0;
      sample_o                   <= 1'b0;
      dac_code_o                 <= 12'h000;
    end else begin
      mux_sel_o                  <= ch_q;                                       // [RL1]
      panel_drv_o                <= busy ? drv_of(ch_q) : 4'h0;                 // [RL2]
      temperature_diode_single_o <= busy && (ch_q == CH_T1);                    // [RL12]
      temperature_diode_ratio_o  <= busy && (ch_q == CH_T2);                    // [RL13]
      sample_o                   <= (st_q == S_SAMPLE);                         // [RL11]
      dac_code_o                 <= sar_q;
    end
  end

  sacc_res_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .res       (res.mem)
  );
endmodule : sacc_ctrl
`default_nettype wire

/* File: inc/sacc_pkg.sv */
`default_nettype none
package sacc_pkg;
  // clock rates; the internal oscillator is emulated by an enable pulse
  localparam int unsigned SYS_CLK_HZ   = 250_000_000;
  localparam int unsigned OSC_HZ       = 4_000_000;
  localparam int unsigned OSC_DIV      = SYS_CLK_HZ / OSC_HZ;
  localparam logic [5:0]  OSC_DIV_M1   = 6'(OSC_DIV - 1);
  localparam logic [1:0]  SAMPLE_TICKS = 2'h3;   // oscillator ticks of sampling

  // register byte offsets
  localparam logic [7:0] CFG0_OFS = 8'h00;
  localparam logic [7:0] CFG1_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] RES_OFS  = 8'h10;   // seven result words from here
  localparam logic [2:0] RES_NUM  = 3'h7;

  // field positions
  localparam int unsigned C0_MODE_LSB = 0;   // [3:0] conversion mode
  localparam int unsigned C0_RES12    = 4;   // 1 = 12-bit
  localparam int unsigned C0_DIV_LSB  = 5;   // [6:5] clock divider
  localparam int unsigned C0_START    = 7;   // write 1 starts
  localparam int unsigned C1_STAB_LSB = 0;   // [7:0] panel settle ticks
  localparam int unsigned C1_SCAN     = 8;   // repeat the sequence
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_DONE     = 1;
  localparam int unsigned ST_ERR      = 2;

  // reset values
  localparam logic [7:0] CFG0_RST = 8'h00;
  localparam logic [8:0] CFG1_RST = 9'h000;

  // divider codes
  localparam logic [1:0] DIV_BY1 = 2'b00;
  localparam logic [1:0] DIV_BY2 = 2'b01;
  localparam logic [1:0] DIV_BY4 = 2'b10;
  localparam logic [1:0] DIV_RSV = 2'b11;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    MODE_X     = 4'h0,
    MODE_Y     = 4'h1,
    MODE_Z     = 4'h2,
    MODE_XY    = 4'h3,
    MODE_XYZ   = 4'h4,
    MODE_AUX   = 4'h5,
    MODE_TSGL  = 4'h6,
    MODE_TDIFF = 4'h7
  } sacc_mode_t;

  typedef enum logic [2:0] {
    CH_X  = 3'h0,
    CH_Y  = 3'h1,
    CH_Z1 = 3'h2,
    CH_Z2 = 3'h3,
    CH_AUX = 3'h4,
    CH_T1 = 3'h5,
    CH_T2 = 3'h6
  } sacc_ch_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_SETTLE = 3'b001,
    S_SAMPLE = 3'b010,
    S_CONV   = 3'b011,
    S_STORE  = 3'b100
  } sacc_state_t;
endpackage : sacc_pkg
`default_nettype wire

/* File: inc/sacc_res_if.sv */
`timescale 1ns/1ps
`default_nettype none
// result store port between controller and its memory
interface sacc_res_if;
  logic        wr_en;
  logic [2:0]  wr_idx;
  logic [11:0] wr_data;
  logic [2:0]  rd_idx;
  logic [11:0] rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : sacc_res_if
`default_nettype wire

/* File: design/sacc_res_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module sacc_res_mem (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  // result port
  sacc_res_if.mem   res
);
  import sacc_pkg::*;

  logic [11:0] mem_q [8];
  logic [11:0] rd_q;

  // one word per channel; a result stays until overwritten
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= 12'h000;
      end
    end else if (res.wr_en) begin
      mem_q[res.wr_idx] <= res.wr_data;
    end
  end

  // registered read port
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_q <= 12'h000;
    end else begin
      rd_q <= mem_q[res.rd_idx];
    end
  end

  assign res.rd_data = rd_q;
endmodule : sacc_res_mem
`default_nettype wire

/* File: bench/sacc_afe_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sacc_afe_model (
  // converter side
  input  wire logic [2:0]  mux_sel_i,
  input  wire logic [11:0] dac_code_i,
  input  wire logic [11:0] vin_i [0:6],
  // comparator result
  output logic             comp_o
);
  // ideal comparator; an unused channel code reads as ground, no kinder than a real pin
  assign comp_o = (mux_sel_i <= 3'h6) && (vin_i[mux_sel_i] >= dac_code_i);
endmodule : sacc_afe_model
`default_nettype wire

/* File: bench/sacc_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl_asserts (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // analog front end
  input wire logic        sample_o,
  input wire logic [2:0]  mux_sel_o,
  input wire logic [3:0]  panel_drv_o,
  input wire logic        temperature_diode_single_o,
  input wire logic        temperature_diode_ratio_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [8:0] smp_cnt_q;
  // length of the sampling strobe; saturates so a stuck strobe cannot wrap
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) smp_cnt_q <= 9'h000;
    else smp_cnt_q <= !sample_o ? 9'h000 : (smp_cnt_q == 9'h1ff ? smp_cnt_q : smp_cnt_q + 9'h001);
  end
  sequence rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  chk_rd_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  chk_panel_x: assert property (sample_o && mux_sel_o == 3'h0 |-> panel_drv_o == 4'b1100)
    else $error("x drive wrong");
  chk_panel_y: assert property (sample_o && mux_sel_o == 3'h1 |-> panel_drv_o == 4'b0011)
    else $error("y drive wrong");
  chk_panel_z: assert property (sample_o && mux_sel_o inside {3'h2, 3'h3} |-> panel_drv_o == 4'b0110)
    else $error("z drive wrong");
  chk_panel_off: assert property (sample_o && mux_sel_o >= 3'h4 |-> panel_drv_o == 4'h0)
    else $error("panel driven off channel");
  chk_diode_bias: assert property (sample_o |-> temperature_diode_single_o == (mux_sel_o == 3'h5)
    && temperature_diode_ratio_o == (mux_sel_o == 3'h6))
    else $error("diode bias wrong");
  chk_sample_len: assert property ($fell(sample_o) |-> smp_cnt_q >= 9'h078 && smp_cnt_q <= 9'h0be)
    else $error("sampling span wrong");
endmodule : sacc_ctrl_asserts
`default_nettype wire

/* File: bench/sacc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
bind sacc_ctrl sacc_ctrl_asserts chk (.sys_clk_i, .rst_b_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .sample_o, .mux_sel_o, .panel_drv_o, .temperature_diode_single_o, .temperature_diode_ratio_o);
module sacc_ctrl_tb;
  import sacc_pkg::*;
  // bus and clock
  logic        sys_clk_i, rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  // analog side
  logic        comp_i, sample_o, temperature_diode_single_o, temperature_diode_ratio_o;
  logic [11:0] dac_code_o;
  logic [2:0]  mux_sel_o;
  logic [3:0]  panel_drv_o;
  logic [11:0] vin [0:6];
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  sacc_ctrl uut (.sys_clk_i, .rst_b_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .comp_i,
    .dac_code_o, .sample_o, .mux_sel_o, .panel_drv_o, .temperature_diode_single_o, .temperature_diode_ratio_o);
  sacc_afe_model afe (.mux_sel_i(mux_sel_o), .dac_code_i(dac_code_o), .vin_i(vin), .comp_o(comp_i));
  // low two bits clear so the 10-bit codes come out exact
  initial vin = '{12'h5a4, 12'ha58, 12'h3c0, 12'hc3c, 12'h7f0, 12'h248, 12'h2d4};
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check(32'(r), 32'(RESP_OKAY));
  endtask : wr_ok
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, exp);
    check(32'(r), 32'(rexp));
  endtask : rd_chk
  function automatic logic [7:0] c0(input sacc_mode_t m, input logic r12, input logic [1:0] dv);
    return {1'b1, dv, r12, m};
  endfunction : c0
  function automatic logic [7:0] ra(input sacc_ch_t ch);
    return RES_OFS + {3'h0, ch, 2'b00};
  endfunction : ra
  // clear flags, start, poll until the sequence is over; returns elapsed cycles
  task automatic run(input logic [7:0] cfg, output int t);
    logic [31:0] st;
    logic [1:0]  r;
    wr_ok(STAT_OFS, 32'h0000_0006);
    t = cyc;
    wr_ok(CFG0_OFS, {24'h0, cfg});
    repeat (4000) begin
      rd(STAT_OFS, st, r);
      if (!st[ST_BUSY]) break;
    end
    t = cyc - t;
  endtask : run
  task automatic t_regs;
    logic [1:0] r;
    rd_chk(CFG0_OFS, 32'h0, RESP_OKAY);
    rd_chk(STAT_OFS, 32'h0, RESP_OKAY);
    rd_chk(ra(CH_X), 32'h0, RESP_OKAY);
    rd_chk(8'h3c, 32'h0, RESP_SLVERR);
    wr(8'h3c, 32'h1, r);
    check(32'(r), 32'(RESP_SLVERR));
    wr_ok(CFG1_OFS, 32'h0000_0103);
    rd_chk(CFG1_OFS, 32'h0000_0103, RESP_OKAY);
    wr_ok(CFG1_OFS, 32'h0000_0001);
  endtask : t_regs
  // rready raised late, so the read answer has to stand and keep its data
  task automatic t_rhold;
    @(posedge sys_clk_i);
    s_axi_araddr  <= CFG1_OFS;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_arready) break;
    end
    s_axi_arvalid <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge sys_clk_i);
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, 32'h0000_0001);
  endtask : t_rhold
  task automatic t_res;
    int t12, t10, t4;
    run(c0(MODE_X, 1'b1, DIV_BY2), t12);
    rd_chk(ra(CH_X), {20'h0, vin[0]}, RESP_OKAY);
    rd_chk(STAT_OFS, 32'h2, RESP_OKAY);
    run(c0(MODE_X, 1'b0, DIV_BY2), t10);
    rd_chk(ra(CH_X), {22'h0, vin[0][11:2]}, RESP_OKAY);
    check(32'(t10 < t12), 32'h1);
    run(c0(MODE_X, 1'b1, DIV_BY4), t4);
    rd_chk(ra(CH_X), {20'h0, vin[0]}, RESP_OKAY);
    check(32'(t4 > t12 + 1000), 32'h1);
  endtask : t_res
  task automatic t_div0;
    int t;
    run(c0(MODE_AUX, 1'b0, DIV_BY1), t);
    rd_chk(ra(CH_AUX), {22'h0, vin[4][11:2]}, RESP_OKAY);
    rd_chk(STAT_OFS, 32'h2, RESP_OKAY);
    wr_ok(ra(CH_AUX), 32'h0);
    // a new input level, so a skipped conversion cannot pass on the old result
    vin[4] <= 12'h6c8;
    run(c0(MODE_AUX, 1'b1, DIV_BY1), t);
    rd_chk(STAT_OFS, 32'h6, RESP_OKAY);
    rd_chk(ra(CH_AUX), {22'h0, vin[4][11:2]}, RESP_OKAY);
    run(c0(MODE_Y, 1'b1, DIV_RSV), t);
    rd_chk(STAT_OFS, 32'h4, RESP_OKAY);
    rd_chk(ra(CH_Y), 32'h0, RESP_OKAY);
  endtask : t_div0
  task automatic t_temp;
    int t;
    run(c0(MODE_TSGL, 1'b1, DIV_BY2), t);
    rd_chk(ra(CH_T1), {20'h0, vin[5]}, RESP_OKAY);
    rd_chk(ra(CH_T2), 32'h0, RESP_OKAY);
    run(c0(MODE_TDIFF, 1'b1, DIV_BY2), t);
    rd_chk(ra(CH_T2), {20'h0, vin[6]}, RESP_OKAY);
  endtask : t_temp
  task automatic t_panel;
    int ta, tz;
    run(c0(MODE_XYZ, 1'b1, DIV_BY2), ta);
    for (int i = 0; i < 4; i++) rd_chk(ra(sacc_ch_t'(i)), {20'h0, vin[i]}, RESP_OKAY);
    wr_ok(CFG1_OFS, 32'h0);
    // undivided clock keeps the prescaler phase out of the comparison
    run(c0(MODE_Y, 1'b0, DIV_BY1), ta);
    wr_ok(CFG1_OFS, 32'h8);
    run(c0(MODE_Y, 1'b0, DIV_BY1), tz);
    // eight settle ticks, less or more one tick of start phase and poll slack
    check(32'(tz - ta >= 7 * OSC_DIV - 8), 32'h1);
    check(32'(tz - ta <= 9 * OSC_DIV + 8), 32'h1);
  endtask : t_panel
  task automatic summarize;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    rst_b_i = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_rhold;
    t_res;
    t_div0;
    t_temp;
    t_panel;
    summarize;
  end
  // the full sequence needs roughly 23000 cycles
  initial begin
    repeat (70000) @(posedge sys_clk_i);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize;
  end
endmodule : sacc_ctrl_tb
`default_nettype wire
